// [rtl/otl_pkg.sv]
package otl_pkg;
	// limit selection digit codes
	localparam logic [3:0] FWD_SEL_ENABLE    = 4'h1;
	localparam logic [3:0] REV_SEL_ENABLE    = 4'h2;
	localparam logic [3:0] SEL_DISABLE       = 4'h8;
	localparam logic [3:0] FWD_SEL_RESET     = 4'h1;
	localparam logic [3:0] REV_SEL_RESET     = 4'h2;
	// stop method digits
	localparam logic [3:0] OT_STOP_BY_SERVO_OFF = 4'h0;
	localparam logic [3:0] OT_DECEL_TRQ_ZCLAMP  = 4'h1;
	localparam logic [3:0] OT_DECEL_TRQ_COAST   = 4'h2;
	localparam logic [3:0] OT_DECEL_TIME_ZCLAMP = 4'h3;
	localparam logic [3:0] OT_DECEL_TIME_COAST  = 4'h4;
	localparam logic [3:0] OFF_STOP_DB_HOLD     = 4'h0;
	localparam logic [3:0] OFF_STOP_DB_COAST    = 4'h1;
	localparam logic [3:0] OFF_STOP_COAST       = 4'h2;
	localparam logic [7:0] STOP_METHOD_RESET    = 8'h00;
	// torque and time settings
	localparam logic [9:0]  ESTOP_TRQ_MAX   = 10'h320;
	localparam logic [9:0]  ESTOP_TRQ_RESET = 10'h320;
	localparam logic [13:0] DECEL_TIME_MAX  = 14'h2710;
	localparam logic [13:0] DECEL_TIME_RESET = 14'h0000;
	localparam int CLK_HZ     = 40000000;
	localparam int DECEL_UNIT_US = 1000;
	localparam int MS_CYCLES  = CLK_HZ / 1000000 * DECEL_UNIT_US;
	localparam int SPEED_W    = 16;
	// stop state machine
	typedef enum logic [4:0] {
		ST_RUN   = 5'h01,
		ST_DECEL = 5'h02,
		ST_ZCLMP = 5'h04,
		ST_COAST = 5'h08,
		ST_DBRK  = 5'h10
	} otl_state_t;
endpackage

// [rtl/otl_ms_tick.sv]
`timescale 1ns/1ps
// one-cycle enable every millisecond
module otl_ms_tick (
	input  wire logic CLK,
	input  wire logic RESET_N,
	input  wire logic run,
	output logic      tick
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic        nxt_tick;

	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_tick = 1'b0;
		if (!run) begin
			nxt_cnt = 16'h0000;
		end else if (cnt_ff == 16'(otl_pkg::MS_CYCLES - 1)) begin
			nxt_cnt  = 16'h0000;
			nxt_tick = 1'b1;
		end else begin
			nxt_cnt = cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			cnt_ff <= 16'h0000;
			tick   <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick   <= nxt_tick;
		end
	end
endmodule // otl_ms_tick

// [rtl/otl_limit_stop.sv]
`timescale 1ns/1ps
// Function
// - forward limit on allows forward drive; off blocks it, forward overtravel
// - reverse limit on allows reverse drive; off blocks it, reverse overtravel
// - during overtravel, drive in the opposite direction is still executed
// - forward select 1 enables forward overtravel, 8 disables it
// - reverse select 2 enables reverse overtravel, 8 disables it
// - default stop method stops by dynamic brake
// - methods 1 and 2 decelerate by stop torque, then zero clamp or coast
// - methods 3 and 4 decelerate by ramp time, then zero clamp or coast
// - torque control stops by brake or coast per servo-off digit, then coasts
// - methods 1 and 2 use stop torque as maximum torque
// - stop torque 0 to 800 percent, default 800, used immediately
// - applied stop torque never exceeds the motor maximum torque
// - decel time 0 to 10000 ms, default 0, used immediately
// - decel time zero commands zero speed at once
// - decel time is the ramp from maximum speed to zero
// - warning enable 0 disables, 1 enables, used immediately
// - warning raised only when overtravel occurs with servo on
// - warning is latched so brief limit pulses are seen
// - warning alone neither stops the motor nor blocks motion
// - warn only in reference direction; either direction with no reference
// - servo on during existing overtravel raises no warning
// - clear command clears unless a new overtravel edge arrives in the same cycle; re-detection waits until overtravel ends
// - warning still raised after a software limit was detected
module otl_limit_stop (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        FWD_LIMIT_IN,
	input  wire logic        REV_LIMIT_IN,
	input  wire logic [3:0]  FWD_LIMIT_SELECT,
	input  wire logic [3:0]  REV_LIMIT_SELECT,
	input  wire logic [7:0]  STOP_METHOD_SELECT,
	input  wire logic [9:0]  ESTOP_TORQUE_LIMIT,
	input  wire logic [9:0]  MOTOR_MAX_TORQUE,
	input  wire logic [13:0] STOP_DECEL_TIME,
	input  wire logic [15:0] MOTOR_MAX_SPEED,
	input  wire logic [15:0] MOTOR_SPEED,
	input  wire logic        LIMIT_WARNING_ENABLE,
	input  wire logic        CLEAR_ALARMS_CMD,
	input  wire logic        SERVO_ON,
	input  wire logic        TORQUE_MODE,
	input  wire logic        REF_FWD,
	input  wire logic        REF_REV,
	input  wire logic        SOFT_LIMIT_HIT,
	output logic             FWD_DRIVE_OK,
	output logic             REV_DRIVE_OK,
	output logic             FWD_OVERTRAVEL,
	output logic             REV_OVERTRAVEL,
	output logic             STOP_ACTIVE,
	output logic             DYN_BRAKE,
	output logic             COAST,
	output logic             ZERO_CLAMP,
	output logic             TORQUE_LIMIT_EN,
	output logic [9:0]       TORQUE_LIMIT,
	output logic [15:0]      SPEED_LIMIT,
	output logic             OT_WARNING
);
	logic [3:0]  fsel_ff, rsel_ff;
	logic [7:0]  smeth_ff;
	logic        cfg_done_ff;
	logic [3:0]  nxt_fsel, nxt_rsel;
	logic [7:0]  nxt_smeth;
	logic        nxt_cfg_done;
	otl_pkg::otl_state_t st_ff, nxt_st;
	logic [15:0] spd_ff, nxt_spd;
	logic        warn_ff, nxt_warn;
	logic        supp_ff, nxt_supp;
	logic        srv_ff, nxt_srv;
	logic        fot_ff, rot_ff, nxt_fot, nxt_rot;
	logic        ms_tick;
	logic        fwd_ot, rev_ot, any_ot, warn_cand;
	logic [3:0]  ot_digit, off_digit;
	logic [9:0]  trq;
	logic [15:0] step;
	// next values of the registered outputs
	logic        nxt_fwd_ok;
	logic        nxt_rev_ok;
	logic        nxt_fwd_otv;
	logic        nxt_rev_otv;
	logic        nxt_stop_act;
	logic        nxt_dbrk;
	logic        nxt_coast;
	logic        nxt_zclamp;
	logic        nxt_tle;
	logic [9:0]  nxt_tlim;
	logic [15:0] nxt_slim;

	function automatic logic sel_enabled(input logic [3:0] sel, input logic [3:0] en_code);
		sel_enabled = (sel == en_code);
	endfunction

	function automatic logic [9:0] min10(input logic [9:0] a, input logic [9:0] b);
		min10 = (a < b) ? a : b;
	endfunction

	// settings caught once after reset; later changes need a restart
	always_comb begin
		nxt_fsel     = fsel_ff;
		nxt_rsel     = rsel_ff;
		nxt_smeth    = smeth_ff;
		nxt_cfg_done = 1'b1;
		if (!cfg_done_ff) begin
			nxt_fsel  = FWD_LIMIT_SELECT;
			nxt_rsel  = REV_LIMIT_SELECT;
			nxt_smeth = STOP_METHOD_SELECT;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			fsel_ff     <= otl_pkg::FWD_SEL_RESET;
			rsel_ff     <= otl_pkg::REV_SEL_RESET;
			smeth_ff    <= otl_pkg::STOP_METHOD_RESET;
			cfg_done_ff <= 1'b0;
		end else begin
			fsel_ff     <= nxt_fsel;
			rsel_ff     <= nxt_rsel;
			smeth_ff    <= nxt_smeth;
			cfg_done_ff <= nxt_cfg_done;
		end
	end

	// limit inputs are active-on: off means overtravel in that direction
	assign fwd_ot    = !FWD_LIMIT_IN && sel_enabled(fsel_ff, otl_pkg::FWD_SEL_ENABLE);
	assign rev_ot    = !REV_LIMIT_IN && sel_enabled(rsel_ff, otl_pkg::REV_SEL_ENABLE);
	assign ot_digit  = smeth_ff[7:4];
	assign off_digit = smeth_ff[3:0];
	assign trq       = min10(min10(ESTOP_TORQUE_LIMIT, otl_pkg::ESTOP_TRQ_MAX),
		MOTOR_MAX_TORQUE);
	// ramp per ms scaled from maximum speed over the programmed time
	// integer divide truncates, so a stop may end a little after the programmed time
	assign step      = (STOP_DECEL_TIME == 14'h0000) ? MOTOR_MAX_SPEED :
		16'(MOTOR_MAX_SPEED / 16'(STOP_DECEL_TIME));
	// a stop runs unless the reference points away from the blocked direction
	assign any_ot    = (fwd_ot && !REF_REV) || (rev_ot && !REF_FWD);

	// tick counter restarts with every stop, so each step is a full millisecond
	otl_ms_tick u_ms_tick (
		.CLK     (CLK),
		.RESET_N (RESET_N),
		.run     (st_ff == otl_pkg::ST_DECEL),
		.tick    (ms_tick)
	);

	always_comb begin
		nxt_st  = st_ff;
		nxt_spd = spd_ff;
		case (st_ff)
			otl_pkg::ST_RUN: begin
				nxt_spd = MOTOR_SPEED;
				if (any_ot && SERVO_ON) begin
					if (TORQUE_MODE) begin
						nxt_st = (off_digit == otl_pkg::OFF_STOP_COAST) ?
							otl_pkg::ST_COAST : otl_pkg::ST_DBRK;
					end else begin
						case (ot_digit)
							otl_pkg::OT_DECEL_TRQ_ZCLAMP, otl_pkg::OT_DECEL_TRQ_COAST,
							otl_pkg::OT_DECEL_TIME_ZCLAMP, otl_pkg::OT_DECEL_TIME_COAST:
								nxt_st = otl_pkg::ST_DECEL;
							default:
								nxt_st = (off_digit == otl_pkg::OFF_STOP_COAST) ?
									otl_pkg::ST_COAST : otl_pkg::ST_DBRK;
						endcase
					end
				end
			end
			// time stops ramp once per ms; torque stops end when the motor reports rest
			otl_pkg::ST_DECEL: begin
				if (ot_digit == otl_pkg::OT_DECEL_TIME_ZCLAMP ||
					ot_digit == otl_pkg::OT_DECEL_TIME_COAST) begin
					if (STOP_DECEL_TIME == 14'h0000) begin
						nxt_spd = 16'h0000;
					end else if (ms_tick) begin
						nxt_spd = (spd_ff > step) ? spd_ff - step : 16'h0000;
					end
				end else if (MOTOR_SPEED == 16'h0000) begin
					nxt_spd = 16'h0000;
				end
				if (nxt_spd == 16'h0000) begin
					nxt_st = (ot_digit == otl_pkg::OT_DECEL_TRQ_ZCLAMP ||
						ot_digit == otl_pkg::OT_DECEL_TIME_ZCLAMP) ?
						otl_pkg::ST_ZCLMP : otl_pkg::ST_COAST;
				end
				if (!any_ot) begin
					nxt_st = otl_pkg::ST_RUN;
				end
			end
			// hold states release once the blocked direction is no longer in play
			otl_pkg::ST_ZCLMP, otl_pkg::ST_COAST: begin
				nxt_spd = 16'h0000;
				if (!any_ot) begin
					nxt_st = otl_pkg::ST_RUN;
				end
			end
			// brake holds unless the servo-off digit asks for coasting afterwards or a torque-mode stop reaches rest
			otl_pkg::ST_DBRK: begin
				nxt_spd = 16'h0000;
				if (!any_ot) begin
					nxt_st = otl_pkg::ST_RUN;
				end else if (off_digit == otl_pkg::OFF_STOP_DB_COAST ||
					(TORQUE_MODE && MOTOR_SPEED == 16'h0000)) begin
					nxt_st = otl_pkg::ST_COAST;
				end
			end
			default: nxt_st = otl_pkg::ST_RUN;
		endcase
	end

	// warning: direction filtered, needs a fresh edge while servo stays on
	assign warn_cand = (fwd_ot && !REF_REV) || (rev_ot && !REF_FWD);

	always_comb begin
		nxt_fot  = fwd_ot;
		nxt_rot  = rev_ot;
		nxt_srv  = SERVO_ON;
		nxt_supp = supp_ff;
		nxt_warn = warn_ff;
		// suppression after a clear lasts only while a switch is still off
		if (!(fwd_ot || rev_ot)) begin
			nxt_supp = 1'b0;
		end
		if (CLEAR_ALARMS_CMD) begin
			nxt_warn = 1'b0;
			nxt_supp = fwd_ot || rev_ot;
		end
		// new overtravel seen while servo was already on; soft limit does not mask
		if (LIMIT_WARNING_ENABLE && SERVO_ON && srv_ff && !supp_ff && warn_cand &&
			((fwd_ot && !fot_ff) || (rev_ot && !rot_ff))) begin
			nxt_warn = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			st_ff   <= otl_pkg::ST_RUN;
			spd_ff  <= 16'h0000;
			warn_ff <= 1'b0;
			supp_ff <= 1'b0;
			srv_ff  <= 1'b0;
			fot_ff  <= 1'b0;
			rot_ff  <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			spd_ff  <= nxt_spd;
			warn_ff <= nxt_warn;
			supp_ff <= nxt_supp;
			srv_ff  <= nxt_srv;
			fot_ff  <= nxt_fot;
			rot_ff  <= nxt_rot;
		end
	end

	// outputs registered; warning never feeds the stop logic
	// one cycle of lag keeps every output straight off a flop
	always_comb begin
		nxt_fwd_ok   = !fwd_ot;
		nxt_rev_ok   = !rev_ot;
		nxt_fwd_otv  = fwd_ot;
		nxt_rev_otv  = rev_ot;
		nxt_stop_act = (nxt_st != otl_pkg::ST_RUN);
		nxt_dbrk     = (nxt_st == otl_pkg::ST_DBRK);
		nxt_coast    = (nxt_st == otl_pkg::ST_COAST);
		nxt_zclamp   = (nxt_st == otl_pkg::ST_ZCLMP);
		nxt_tle      = (nxt_st == otl_pkg::ST_DECEL) &&
			(ot_digit == otl_pkg::OT_DECEL_TRQ_ZCLAMP ||
			ot_digit == otl_pkg::OT_DECEL_TRQ_COAST);
		nxt_tlim     = trq;
		nxt_slim     = nxt_spd;
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			FWD_DRIVE_OK    <= 1'b0;
			REV_DRIVE_OK    <= 1'b0;
			FWD_OVERTRAVEL  <= 1'b0;
			REV_OVERTRAVEL  <= 1'b0;
			STOP_ACTIVE     <= 1'b0;
			DYN_BRAKE       <= 1'b0;
			COAST           <= 1'b0;
			ZERO_CLAMP      <= 1'b0;
			TORQUE_LIMIT_EN <= 1'b0;
			TORQUE_LIMIT    <= otl_pkg::ESTOP_TRQ_RESET;
			SPEED_LIMIT     <= 16'h0000;
			OT_WARNING      <= 1'b0;
		end else begin
			FWD_DRIVE_OK    <= nxt_fwd_ok;
			REV_DRIVE_OK    <= nxt_rev_ok;
			FWD_OVERTRAVEL  <= nxt_fwd_otv;
			REV_OVERTRAVEL  <= nxt_rev_otv;
			STOP_ACTIVE     <= nxt_stop_act;
			DYN_BRAKE       <= nxt_dbrk;
			COAST           <= nxt_coast;
			ZERO_CLAMP      <= nxt_zclamp;
			TORQUE_LIMIT_EN <= nxt_tle;
			TORQUE_LIMIT    <= nxt_tlim;
			SPEED_LIMIT     <= nxt_slim;
			OT_WARNING      <= nxt_warn;
		end
	end
endmodule // otl_limit_stop

// [tb/otl_limit_stop_properties.sv]
`timescale 1ns/1ps
module otl_limit_stop_chk (
	input wire logic       CLK,
	input wire logic       RESET_N,
	input wire logic       FWD_LIMIT_IN,
	input wire logic       REV_LIMIT_IN,
	input wire logic [9:0] MOTOR_MAX_TORQUE,
	input wire logic       LIMIT_WARNING_ENABLE,
	input wire logic       CLEAR_ALARMS_CMD,
	input wire logic       SERVO_ON,
	input wire logic       FWD_DRIVE_OK,
	input wire logic       REV_DRIVE_OK,
	input wire logic       FWD_OVERTRAVEL,
	input wire logic       REV_OVERTRAVEL,
	input wire logic [9:0] TORQUE_LIMIT,
	input wire logic       OT_WARNING
);
	logic [1:0] up_ff;
	// settings latch on the first edge after release, so outputs are judged from the third
	always_ff @(posedge CLK)
		up_ff <= RESET_N ? {up_ff[0], 1'b1} : 2'h0;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	property p_fwd; up_ff[1] && $past(FWD_LIMIT_IN) |-> FWD_DRIVE_OK && !FWD_OVERTRAVEL; endproperty
	a_fwd: assert property (p_fwd) else $error("fwd blocked");
	property p_rev; up_ff[1] && $past(REV_LIMIT_IN) |-> REV_DRIVE_OK && !REV_OVERTRAVEL; endproperty
	a_rev: assert property (p_rev) else $error("rev blocked");
	property p_trq; up_ff[1] |-> TORQUE_LIMIT <= $past(MOTOR_MAX_TORQUE); endproperty
	a_trq: assert property (p_trq) else $error("torque over motor max");
	property p_son; $rose(OT_WARNING) |-> $past(SERVO_ON); endproperty
	a_son: assert property (p_son) else $error("warning with servo off");
	property p_wen; $rose(OT_WARNING) |-> $past(LIMIT_WARNING_ENABLE); endproperty
	a_wen: assert property (p_wen) else $error("warning while disabled");
	property p_hold; OT_WARNING && LIMIT_WARNING_ENABLE && !CLEAR_ALARMS_CMD |=> OT_WARNING; endproperty
	a_hold: assert property (p_hold) else $error("warning dropped");
	property p_clr; (CLEAR_ALARMS_CMD && FWD_LIMIT_IN && REV_LIMIT_IN)[*3] |=> !OT_WARNING; endproperty
	a_clr: assert property (p_clr) else $error("warning not cleared");
	property p_ot_on;
		(!SERVO_ON && !OT_WARNING && !FWD_LIMIT_IN && REV_LIMIT_IN)[*2] ##1
		(SERVO_ON && !FWD_LIMIT_IN && REV_LIMIT_IN)[*2] |=> !OT_WARNING;
	endproperty
	a_ot_on: assert property (p_ot_on) else $error("warning at servo on");
endmodule // otl_limit_stop_chk

bind otl_limit_stop otl_limit_stop_chk u_chk (.*);

// [tb/otl_axis_model.sv]
`timescale 1ns/1ps
// axis between two end switches; it only moves where the drive lets it
module otl_axis_model (
	input  wire logic clk,
	input  wire logic home,
	input  wire logic ref_fwd,
	input  wire logic ref_rev,
	input  wire logic fwd_ok,
	input  wire logic rev_ok,
	output logic      fwd_limit_in,
	output logic      rev_limit_in
);
	int pos = 8;
	always @(posedge clk) begin
		if (home)
			pos <= 8;
		else if (ref_fwd && fwd_ok)
			pos <= pos + 1;
		else if (ref_rev && rev_ok)
			pos <= pos - 1;
	end
	assign fwd_limit_in = pos < 12;
	assign rev_limit_in = pos > 3;
endmodule // otl_axis_model

// [tb/otl_limit_stop_tb_top.sv]
`timescale 1ns/1ps
module otl_limit_stop_tb_top;
	logic        clk = 1'b0, clr = 1'b0, rst_n, srv, rf, rr, wen, tmode;
	logic        fin, rin, fok, rok, fot, rot, db, cst, zc, warn, sa, tle;
	logic [3:0]  fsel, rsel;
	logic [7:0]  stop;
	logic [9:0]  obs;
	logic [13:0] dt;
	logic [9:0]  est = 10'h384, mtq = 10'h3FF, tl;
	logic [15:0] sl, mspd;
	int          num_errors = 0, samples_checked = 0, waited = 0;
	logic [7:0]  sm [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h12};
	logic [2:0]  sx [6] = '{3'h4, 3'h1, 3'h2, 3'h1, 3'h2, 3'h2};
	always #12.5 clk = ~clk;
	otl_limit_stop u_otl_limit_stop (.CLK(clk), .RESET_N(rst_n), .FWD_LIMIT_IN(fin),
		.REV_LIMIT_IN(rin), .FWD_LIMIT_SELECT(fsel), .REV_LIMIT_SELECT(rsel),
		.STOP_METHOD_SELECT(stop), .ESTOP_TORQUE_LIMIT(est), .MOTOR_MAX_TORQUE(mtq),
		.STOP_DECEL_TIME(dt), .MOTOR_MAX_SPEED(16'h1000), .MOTOR_SPEED(mspd),
		.LIMIT_WARNING_ENABLE(wen), .CLEAR_ALARMS_CMD(clr), .SERVO_ON(srv),
		.TORQUE_MODE(tmode), .REF_FWD(rf), .REF_REV(rr), .SOFT_LIMIT_HIT(1'b1),
		.FWD_DRIVE_OK(fok), .REV_DRIVE_OK(rok), .FWD_OVERTRAVEL(fot), .REV_OVERTRAVEL(rot),
		.STOP_ACTIVE(sa), .DYN_BRAKE(db), .COAST(cst), .ZERO_CLAMP(zc), .TORQUE_LIMIT_EN(tle),
		.TORQUE_LIMIT(tl), .SPEED_LIMIT(sl), .OT_WARNING(warn));
	otl_axis_model u_axis (.clk(clk), .home(!rst_n), .ref_fwd(rf), .ref_rev(rr),
		.fwd_ok(fok), .rev_ok(rok), .fwd_limit_in(fin), .rev_limit_in(rin));
	assign obs = {tle, sa, fin, fot, warn, db, cst, zc, rin, 1'b0};
	task automatic chk(input string n, input logic [15:0] s, e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_sig(input int i, input logic v);
		for (int k = 0; k < 60 && obs[i] !== v; k++)
			cyc(1);
		if (obs[i] !== v) begin
			num_errors++;
			$display("[FAIL] wait %0d exp %b got %b", i, v, obs[i]);
			complete_run();
		end
	endtask
	// selects only take effect at a restart, so every setup goes through here
	task automatic restart(input logic [3:0] f, r, input logic [7:0] m);
		{rst_n, fsel, rsel, stop, rf, rr, srv, wen, tmode} = {1'b0, f, r, m, 5'h00};
		{dt, mspd} = 30'h0;
		cyc(3);
		chk("reset torque", tl, 16'h0320);
		rst_n = 1'b1;
		cyc(2);
	endtask
	initial begin
		restart(4'h1, 4'h2, 8'h00);
		chk("torque clip", tl, 16'h0320);
		mtq = 10'h12C;
		cyc(2);
		chk("torque motor", tl, 16'h012C);
		{wen, srv, rf} = 3'h7;
		wait_sig(6, 1'b1);
		cyc(2);
		chk("fwd stop", {fok, rok, db, warn}, 4'h7);
		{rf, rr} = 2'h1;
		wait_sig(7, 1'b1);
		cyc(2);
		chk("leave", {fot, warn}, 2'h1);
		chk("reverse runs", sa, 1'b0);
		{clr, rr} = 2'h2;
		cyc(3);
		clr = 1'b0;
		chk("clear", warn, 1'b0);
		{srv, rf} = 2'h1;
		wait_sig(6, 1'b1);
		cyc(2);
		chk("servo off", warn, 1'b0);
		srv = 1'b1;
		cyc(4);
		chk("servo on", warn, 1'b0);
		for (int s = 0; s < 6; s++) begin
			restart(4'h1, 4'h2, sm[s]);
			{tmode, srv, rf} = {s == 5, 2'h3};
			wait_sig(2 + (sx[s] >> 1), 1'b1);
			cyc(2);
			chk("stop", {db, cst, zc, warn}, {sx[s], 1'b0});
			chk("stop active", sa, 1'b1);
			if (sx[s][0])
				chk("clamp speed", sl, 16'h0000);
		end
		// torque stop lasts while the motor still turns
		restart(4'h1, 4'h2, 8'h10);
		mspd = 16'h0400;
		{srv, rf} = 2'h3;
		wait_sig(8, 1'b1);
		cyc(3);
		chk("trq decel", {tle, zc}, 2'h2);
		chk("trq cap", tl, 16'h012C);
		chk("trq speed", sl, 16'h0400);
		mspd = 16'h0000;
		wait_sig(2, 1'b1);
		chk("trq clamp", {tle, zc}, 2'h1);
		// timed ramp: full speed over 2 ms drops by half after one ms
		restart(4'h1, 4'h2, 8'h30);
		{dt, mspd} = {14'h0002, 16'h1000};
		{srv, rf} = 2'h3;
		wait_sig(8, 1'b1);
		chk("ramp start", sl, 16'h1000);
		chk("ramp no cap", tle, 1'b0);
		for (waited = 0; waited < 40100 && sl === 16'h1000; waited++)
			cyc(1);
		chk("ramp ms", 16'(waited), 16'(otl_pkg::MS_CYCLES + 1));
		chk("ramp step", sl, 16'h0800);
		dt = 14'h0000;
		cyc(1);
		chk("zero time", sl, 16'h0000);
		chk("zero time clamp", zc, 1'b1);
		restart(4'h8, 4'h8, 8'h00);
		{fsel, rsel, srv, rf} = {4'h1, 4'h2, 2'h3};
		wait_sig(7, 1'b0);
		cyc(2);
		chk("fwd off", {fot, fok}, 2'h1);
		{rf, rr} = 2'h1;
		wait_sig(1, 1'b0);
		cyc(2);
		chk("rev off", {rot, rok}, 2'h1);
		complete_run();
	end
endmodule // otl_limit_stop_tb_top
